//--- hw/isc_pkg.sv
`default_nettype none
package isc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] ISC_IDX_ILIM = 6'h14;
  localparam logic [5:0] ISC_IDX_PHY = 6'h16;
  localparam logic [5:0] ISC_IDX_DBNC = 6'h18;
  localparam logic [5:0] ISC_IDX_HEADROOM = 6'h1b;
  localparam logic [5:0] ISC_IDX_STATUS = 6'h1c;
  localparam int ISC_ADDR_W = 8;
  localparam int ISC_NREG = 4;
  localparam int ISC_SLOT_ILIM = 0;
  localparam int ISC_SLOT_PHY = 1;
  localparam int ISC_SLOT_DBNC = 2;
  localparam int ISC_SLOT_HEADROOM = 3;
  localparam int ISC_SLOT_STATUS = 4;
  localparam int ISC_SEL_W = 5;
  // Reset values and writable-bit masks, slot order 3..0
  localparam logic [ISC_NREG-1:0][7:0] ISC_REG_DEFAULT = {8'h00, 8'h00, 8'h01, 8'h68};
  localparam logic [ISC_NREG-1:0][7:0] ISC_REG_MASK = {8'h07, 8'h3f, 8'h06, 8'hf8};
  // Field positions
  localparam int ISC_ILIM_LSB = 3;
  localparam int ISC_ILIM_MSB = 7;
  localparam int ISC_PHY_VSEL_BIT = 1;
  localparam int ISC_PHY_EN_BIT = 2;
  localparam int ISC_OV_LSB = 0;
  localparam int ISC_OV_MSB = 1;
  localparam int ISC_PHYDB_LSB = 2;
  localparam int ISC_PHYDB_MSB = 3;
  localparam int ISC_WAKE_LSB = 4;
  localparam int ISC_WAKE_MSB = 5;
  localparam int ISC_HRDB_LSB = 0;
  localparam int ISC_HRDB_MSB = 1;
  localparam int ISC_HRTH_BIT = 2;
  // Status register bits
  localparam int ISC_ST_ILIM_RSVD = 0;
  localparam int ISC_ST_OV_RSVD = 1;
  localparam int ISC_ST_HR_RSVD = 2;
  localparam int ISC_ST_LOADED = 3;
  // Current limit coding
  localparam logic [4:0] ISC_ILIM_FINE_LAST = 5'h08;
  localparam logic [4:0] ISC_ILIM_MID_LAST = 5'h0b;
  localparam logic [4:0] ISC_ILIM_COARSE_FIRST = 5'h0c;
  localparam logic [4:0] ISC_ILIM_TOP = 5'h14;
  localparam logic [10:0] ISC_ILIM_FINE_BASE_MA = 11'h00a;
  localparam logic [10:0] ISC_ILIM_FINE_STEP_MA = 11'h005;
  localparam logic [10:0] ISC_ILIM_MID_BASE_MA = 11'h064;
  localparam logic [10:0] ISC_ILIM_MID_STEP_MA = 11'h032;
  localparam logic [10:0] ISC_ILIM_COARSE_BASE_MA = 11'h12c;
  localparam logic [10:0] ISC_ILIM_COARSE_STEP_MA = 11'h064;
  localparam logic [10:0] ISC_ILIM_TOP_MA = 11'h5dc;
  // Times in microseconds per code, analog figures in mV
  localparam logic [3:0][13:0] ISC_OV_DBNC_US = {14'h2710, 14'h03e8, 14'h0064, 14'h000a};
  localparam logic [3:0][13:0] ISC_HR_DBNC_US = {14'h2710, 14'h03e8, 14'h0064, 14'h0000};
  localparam logic [3:0][16:0] ISC_WAKE_US = {17'h186a0, 17'h07d00, 17'h03e80, 17'h01f40};
  localparam logic [12:0] ISC_PHY_LOW_MV = 13'h0ce4;
  localparam logic [12:0] ISC_PHY_HIGH_MV = 13'h1324;
  localparam logic [7:0] ISC_MARGIN_LOW_MV = 8'h32;
  localparam logic [7:0] ISC_MARGIN_HIGH_MV = 8'haf;
  localparam logic [1:0] ISC_CODE_RSVD = 2'h0;
  // AXI responses
  localparam logic [1:0] ISC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] ISC_RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

//--- hw/isc_field_if.sv
`timescale 1ns/100ps
`default_nettype none
interface isc_field_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  logic loaded;
  modport owner(input wr_en, input wr_data, output value, output loaded);
  modport user(output wr_en, output wr_data, input value, input loaded);
endinterface
`default_nettype wire

//--- hw/isc_cfg_byte.sv
`timescale 1ns/100ps
`default_nettype none
module isc_cfg_byte #(
  parameter logic [7:0] DEFAULT = 8'h00,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] fuse_val,
  isc_field_if.owner port
);
  logic [7:0] value_reg;
  logic loaded_reg;

  // Fuse copy happens once after reset release; it wins over a same-cycle write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= DEFAULT;
    end else if (!loaded_reg) begin
      value_reg <= (fuse_val & MASK) | (DEFAULT & ~MASK); // [RQ12]
    end else if (port.wr_en) begin
      value_reg <= (port.wr_data & MASK) | (value_reg & ~MASK); // [RQ13]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  assign port.value = value_reg;
  assign port.loaded = loaded_reg;
endmodule // isc_cfg_byte
`default_nettype wire

//--- hw/isc_setting_decode.sv
`timescale 1ns/100ps
`default_nettype none
module isc_setting_decode (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] ilim_code,
  input wire logic phy_vsel,
  input wire logic [1:0] ov_code,
  input wire logic [1:0] wake_code,
  input wire logic [1:0] hr_code,
  input wire logic hr_thresh,
  output logic [10:0] current_limit_ma,
  output logic [12:0] phy_supply_mv,
  output logic [13:0] ov_debounce_us,
  output logic [16:0] wakeup_delay_us,
  output logic [13:0] headroom_debounce_us,
  output logic [7:0] headroom_margin_mv
);
  import isc_pkg::*;
  logic [10:0] ilim_ma;

  always_comb begin
    logic [10:0] code_w;
    code_w = {6'h00, ilim_code};
    if (ilim_code <= ISC_ILIM_FINE_LAST) begin
      ilim_ma = ISC_ILIM_FINE_BASE_MA + 11'(code_w * ISC_ILIM_FINE_STEP_MA); // [RQ2]
    end else if (ilim_code <= ISC_ILIM_MID_LAST) begin
      ilim_ma = ISC_ILIM_MID_BASE_MA
        + 11'((code_w - {6'h00, ISC_ILIM_FINE_LAST} - 11'h001) * ISC_ILIM_MID_STEP_MA); // [RQ2]
    end else if (ilim_code < ISC_ILIM_TOP) begin
      ilim_ma = ISC_ILIM_COARSE_BASE_MA
        + 11'((code_w - {6'h00, ISC_ILIM_COARSE_FIRST}) * ISC_ILIM_COARSE_STEP_MA); // [RQ2]
    end else begin
      // Reserved codes are undefined; clamp to the top step
      ilim_ma = ISC_ILIM_TOP_MA; // [RQ1]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_limit_ma <= 11'h000;
      phy_supply_mv <= 13'h0000;
      ov_debounce_us <= 14'h0000;
      wakeup_delay_us <= 17'h00000;
      headroom_debounce_us <= 14'h0000;
      headroom_margin_mv <= 8'h00;
    end else begin
      current_limit_ma <= ilim_ma;
      phy_supply_mv <= phy_vsel ? ISC_PHY_HIGH_MV : ISC_PHY_LOW_MV; // [RQ4]
      ov_debounce_us <= ISC_OV_DBNC_US[ov_code]; // [RQ6]
      wakeup_delay_us <= ISC_WAKE_US[wake_code]; // [RQ8]
      headroom_debounce_us <= ISC_HR_DBNC_US[hr_code]; // [RQ9]
      headroom_margin_mv <= hr_thresh ? ISC_MARGIN_HIGH_MV : ISC_MARGIN_LOW_MV; // [RQ10]
    end
  end
endmodule // isc_setting_decode
`default_nettype wire

//--- hw/isc_config_regs.sv
// Summary of operation
// [RQ1] Current limit code in bits 7..3, default 01101, codes 0..20 map 10..1500 mA.
// [RQ2] Codes 0..8 step 5 mA, 9..19 per table, 20 is 1500 mA, above reserved.
// [RQ3] Current limit register returns to default on charger input reset only.
// [RQ4] PHY supply voltage select at bit 1, default 0; 0 is 3.3 V, 1 is 4.9 V.
// [RQ5] PHY regulator enable at bit 2, default 0; 1 enables the regulator.
// [RQ6] Overvoltage debounce bits 1..0: 10 us reserved, 100 us, 1 ms, 10 ms.
// [RQ7] PHY debounce bits 3..2: 0, 16, 32 ms, code 3 unused; not acted upon.
// [RQ8] Wake-up delay bits 5..4: 8, 16, 32 or 100 ms, default code 0.
// [RQ9] Headroom debounce bits 1..0: code 0 reserved, then 100 us, 1 ms, 10 ms.
// [RQ10] Headroom threshold bit 2 selects 50 mV margin at 0, 175 mV at 1.
// [RQ11] All other fields return to default on the core digital reset.
// [RQ12] Fuse-loaded fields take defaults from fuses and stay readable and writable.
// [RQ13] Unused bits keep defaults; reserved codes give undefined behaviour.
`timescale 1ns/100ps
`default_nettype none
module isc_config_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic charger_input_reset_n,
  input wire logic [7:0] fuse_ilim,
  input wire logic [7:0] fuse_phy,
  input wire logic [7:0] fuse_dbnc,
  input wire logic [7:0] fuse_headroom,
  input wire logic [isc_pkg::ISC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [isc_pkg::ISC_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [4:0] input_current_limit_sel,
  output logic phy_supply_voltage_sel,
  output logic phy_regulator_enable,
  output logic [1:0] overvoltage_debounce_sel,
  output logic [1:0] wakeup_delay_sel,
  output logic [1:0] headroom_debounce_sel,
  output logic headroom_threshold_sel,
  output logic [10:0] current_limit_ma,
  output logic [12:0] phy_supply_mv,
  output logic [13:0] ov_debounce_us,
  output logic [16:0] wakeup_delay_us,
  output logic [13:0] headroom_debounce_us,
  output logic [7:0] headroom_margin_mv
);
  import isc_pkg::*;

  // One-hot slot select; bit per register plus the status word
  function automatic logic [ISC_SEL_W-1:0] isc_decode(input logic [ISC_ADDR_W-1:0] addr);
    logic [ISC_SEL_W-1:0] sel;
    sel = '0;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[ISC_ADDR_W-1:2])
        ISC_IDX_ILIM: sel[ISC_SLOT_ILIM] = 1'b1;
        ISC_IDX_PHY: sel[ISC_SLOT_PHY] = 1'b1;
        ISC_IDX_DBNC: sel[ISC_SLOT_DBNC] = 1'b1;
        ISC_IDX_HEADROOM: sel[ISC_SLOT_HEADROOM] = 1'b1;
        ISC_IDX_STATUS: sel[ISC_SLOT_STATUS] = 1'b1;
        default: sel = '0;
      endcase
    end
    return sel;
  endfunction

  logic aw_full_reg;
  logic [ISC_ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_commit;
  logic [ISC_SEL_W-1:0] wr_sel;
  logic [ISC_SEL_W-1:0] rd_sel;
  logic [7:0] rd_byte;
  logic [ISC_NREG-1:0][7:0] reg_value;
  logic [ISC_NREG-1:0][7:0] fuse_value;
  logic [ISC_NREG-1:0] reg_loaded;
  logic [7:0] status_value;
  logic ilim_rsvd;
  logic ov_rsvd;
  logic hr_rsvd;

  assign fuse_value[ISC_SLOT_ILIM] = fuse_ilim;
  assign fuse_value[ISC_SLOT_PHY] = fuse_phy;
  assign fuse_value[ISC_SLOT_DBNC] = fuse_dbnc;
  assign fuse_value[ISC_SLOT_HEADROOM] = fuse_headroom;

  // Write path: address and data are held separately and may arrive in any order
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign wr_commit = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_sel = isc_decode(aw_addr_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata[7:0];
      w_lane0_reg <= s_axi_wstrb[0];
    end else if (wr_commit) begin
      w_full_reg <= 1'b0;
    end
  end

  // Status word is read-only, so a write there is an error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ISC_RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_reg <= 1'b1;
      if (wr_sel == '0) begin
        bresp_reg <= ISC_RESP_DECERR;
      end else if (wr_sel[ISC_SLOT_STATUS]) begin
        bresp_reg <= ISC_RESP_SLVERR;
      end else begin
        bresp_reg <= ISC_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read path: one outstanding read, answered the cycle after acceptance
  assign s_axi_arready = !rvalid_reg;
  assign rd_sel = isc_decode(s_axi_araddr);

  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < ISC_NREG; k++) begin
      if (rd_sel[k]) begin
        rd_byte = reg_value[k];
      end
    end
    if (rd_sel[ISC_SLOT_STATUS]) begin
      rd_byte = status_value;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ISC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= (rd_sel == '0) ? ISC_RESP_DECERR : ISC_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Configuration bytes; the current limit sits on its own reset domain
  isc_field_if fld[ISC_NREG]();

  generate
    for (genvar i = 0; i < ISC_NREG; i++) begin : g_cfg
      logic byte_rst_n;
      if (i == ISC_SLOT_ILIM) begin : g_chg
        assign byte_rst_n = charger_input_reset_n; // [RQ3]
      end else begin : g_core
        assign byte_rst_n = rstn; // [RQ11]
      end
      assign fld[i].wr_en = wr_commit && wr_sel[i] && w_lane0_reg;
      assign fld[i].wr_data = w_data_reg;
      assign reg_value[i] = fld[i].value;
      assign reg_loaded[i] = fld[i].loaded;
      isc_cfg_byte #(
        .DEFAULT(ISC_REG_DEFAULT[i]),
        .MASK(ISC_REG_MASK[i])
      ) u_byte (
        .clk(clk),
        .rst_n(byte_rst_n),
        .fuse_val(fuse_value[i]),
        .port(fld[i])
      );
    end
  endgenerate

  // Field outputs follow the stored bytes directly
  always_comb begin
    input_current_limit_sel = reg_value[ISC_SLOT_ILIM][ISC_ILIM_MSB:ISC_ILIM_LSB]; // [RQ1]
    phy_supply_voltage_sel = reg_value[ISC_SLOT_PHY][ISC_PHY_VSEL_BIT]; // [RQ4]
    phy_regulator_enable = reg_value[ISC_SLOT_PHY][ISC_PHY_EN_BIT]; // [RQ5]
    overvoltage_debounce_sel = reg_value[ISC_SLOT_DBNC][ISC_OV_MSB:ISC_OV_LSB]; // [RQ6]
    wakeup_delay_sel = reg_value[ISC_SLOT_DBNC][ISC_WAKE_MSB:ISC_WAKE_LSB]; // [RQ8]
    headroom_debounce_sel = reg_value[ISC_SLOT_HEADROOM][ISC_HRDB_MSB:ISC_HRDB_LSB]; // [RQ9]
    headroom_threshold_sel = reg_value[ISC_SLOT_HEADROOM][ISC_HRTH_BIT]; // [RQ10]
  end

  // PHY debounce field is stored and read back only; nothing here times it
  logic [1:0] phy_detect_debounce_sel;
  assign phy_detect_debounce_sel = reg_value[ISC_SLOT_DBNC][ISC_PHYDB_MSB:ISC_PHYDB_LSB]; // [RQ7]

  // Reserved codes are flagged so software can see a bad setting
  assign ilim_rsvd = input_current_limit_sel > ISC_ILIM_TOP; // [RQ13]
  assign ov_rsvd = overvoltage_debounce_sel == ISC_CODE_RSVD;
  assign hr_rsvd = headroom_debounce_sel == ISC_CODE_RSVD;

  always_comb begin
    status_value = 8'h00;
    status_value[ISC_ST_ILIM_RSVD] = ilim_rsvd;
    status_value[ISC_ST_OV_RSVD] = ov_rsvd;
    status_value[ISC_ST_HR_RSVD] = hr_rsvd;
    status_value[ISC_ST_LOADED] = &reg_loaded;
  end

  isc_setting_decode u_decode (
    .clk(clk),
    .rstn(rstn),
    .ilim_code(input_current_limit_sel),
    .phy_vsel(phy_supply_voltage_sel),
    .ov_code(overvoltage_debounce_sel),
    .wake_code(wakeup_delay_sel),
    .hr_code(headroom_debounce_sel),
    .hr_thresh(headroom_threshold_sel),
    .current_limit_ma(current_limit_ma),
    .phy_supply_mv(phy_supply_mv),
    .ov_debounce_us(ov_debounce_us),
    .wakeup_delay_us(wakeup_delay_us),
    .headroom_debounce_us(headroom_debounce_us),
    .headroom_margin_mv(headroom_margin_mv)
  );
endmodule // isc_config_regs
`default_nettype wire

//--- tb/isc_config_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module isc_config_regs_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic charger_input_reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] input_current_limit_sel,
  input wire logic phy_supply_voltage_sel,
  input wire logic [1:0] overvoltage_debounce_sel,
  input wire logic [1:0] wakeup_delay_sel,
  input wire logic [1:0] headroom_debounce_sel,
  input wire logic headroom_threshold_sel,
  input wire logic [16:0] wakeup_delay_us,
  input wire logic [13:0] headroom_debounce_us,
  input wire logic [12:0] phy_supply_mv,
  input wire logic [13:0] ov_debounce_us,
  input wire logic [7:0] headroom_margin_mv
);
  import isc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Decodes lag the fuse copy, so hold off two edges after reset
  logic [1:0] age_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age_reg <= 2'h0;
    end else if (!age_reg[1]) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  aw_hold_a: assert property ((s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("write address taken while one is held");
  w_hold_a: assert property ((s_axi_wvalid && s_axi_wready) |=> !s_axi_wready)
    else $error("write data taken while one is held");
  write_resp_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid) |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two edges after acceptance");
  bresp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  read_lat_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after address");
  rdata_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bytes not zero");
  ilim_default_a: assert property (!charger_input_reset_n |->
    input_current_limit_sel == ISC_REG_DEFAULT[ISC_SLOT_ILIM][ISC_ILIM_MSB:ISC_ILIM_LSB])
    else $error("current limit not at default in charger reset");
  phy_decode_a: assert property (age_reg[1] |-> phy_supply_mv ==
    ($past(phy_supply_voltage_sel) ? ISC_PHY_HIGH_MV : ISC_PHY_LOW_MV))
    else $error("phy supply decode wrong");
  ov_decode_a: assert property (age_reg[1] |->
    ov_debounce_us == ISC_OV_DBNC_US[$past(overvoltage_debounce_sel)])
    else $error("overvoltage debounce decode wrong");
  margin_decode_a: assert property (age_reg[1] |-> headroom_margin_mv ==
    ($past(headroom_threshold_sel) ? ISC_MARGIN_HIGH_MV : ISC_MARGIN_LOW_MV))
    else $error("headroom margin decode wrong");
  wake_decode_a: assert property (age_reg[1] |->
    wakeup_delay_us == ISC_WAKE_US[$past(wakeup_delay_sel)])
    else $error("wake-up delay decode wrong");
  hr_decode_a: assert property (age_reg[1] |->
    headroom_debounce_us == ISC_HR_DBNC_US[$past(headroom_debounce_sel)])
    else $error("headroom debounce decode wrong");
  write_cov: cover property (s_axi_bvalid && s_axi_bready);
  decerr_cov: cover property (s_axi_rvalid && s_axi_rresp == ISC_RESP_DECERR);
  chg_cov: cover property ($fell(charger_input_reset_n));
endmodule // isc_config_regs_props
bind isc_config_regs isc_config_regs_props chk_u (.clk(clk), .rstn(rstn),
  .charger_input_reset_n(charger_input_reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .input_current_limit_sel(input_current_limit_sel),
  .phy_supply_voltage_sel(phy_supply_voltage_sel),
  .overvoltage_debounce_sel(overvoltage_debounce_sel),
  .wakeup_delay_sel(wakeup_delay_sel), .headroom_debounce_sel(headroom_debounce_sel),
  .wakeup_delay_us(wakeup_delay_us), .headroom_debounce_us(headroom_debounce_us),
  .headroom_threshold_sel(headroom_threshold_sel), .phy_supply_mv(phy_supply_mv),
  .ov_debounce_us(ov_debounce_us), .headroom_margin_mv(headroom_margin_mv));
`default_nettype wire

//--- tb/isc_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module isc_config_regs_tb;
  import isc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic chg_rst_n = 1'b0;
  logic [7:0] fuse [4];
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, phy_vsel, phy_en, hr_th;
  logic [1:0] bresp, rresp, ov_sel, wake_sel, hr_sel, rsp;
  logic [31:0] rdata, rd;
  logic [4:0] ilim_sel;
  logic [10:0] cur_ma;
  logic [7:0] exp_reg [4];
  logic [7:0] addr_tab [4];
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 98;
  int s;
  always #50 clk = ~clk;
  isc_config_regs dut_u (.clk(clk), .rstn(rstn), .charger_input_reset_n(chg_rst_n),
    .fuse_ilim(fuse[0]), .fuse_phy(fuse[1]), .fuse_dbnc(fuse[2]), .fuse_headroom(fuse[3]),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .input_current_limit_sel(ilim_sel), .phy_supply_voltage_sel(phy_vsel),
    .phy_regulator_enable(phy_en), .overvoltage_debounce_sel(ov_sel),
    .wakeup_delay_sel(wake_sel), .headroom_debounce_sel(hr_sel),
    .headroom_threshold_sel(hr_th), .current_limit_ma(cur_ma), .phy_supply_mv(),
    .ov_debounce_us(), .wakeup_delay_us(), .headroom_debounce_us(), .headroom_margin_mv());
  function automatic logic [10:0] ilim_ma(input logic [4:0] c);
    int v;
    v = c;
    if (v <= 8) return 11'(10 + 5 * v);
    if (v <= 11) return 11'(100 + 50 * (v - 9));
    if (v <= 19) return 11'(300 + 100 * (v - 12));
    return 11'h5dc;
  endfunction
  function automatic logic [7:0] fuse_exp(input int k, input logic [7:0] f);
    return (f & ISC_REG_MASK[k]) | (ISC_REG_DEFAULT[k] & ~ISC_REG_MASK[k]);
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] want);
    chk_data({30'h0, got}, {30'h0, want});
  endtask
  task automatic chk_fields;
    chk_data({18'h0, ilim_sel, phy_en, phy_vsel, wake_sel, ov_sel, hr_th, hr_sel},
      {18'h0, exp_reg[0][7:3], exp_reg[1][2:1], exp_reg[2][5:4], exp_reg[2][1:0], exp_reg[3][2:0]});
  endtask
  // Ready seen at the falling edge is stable up to the rising edge that takes the beat
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] st);
    logic aw_go, w_go, b_go;
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {r[31:8], d};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= r[0];
    do begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      if (b_go) rsp = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      bready <= !b_go;
    end while (!b_go);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_go, r_go;
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= r[0];
    do begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      if (r_go) rd = rdata;
      if (r_go) rsp = rresp;
      @(posedge clk);
      if (ar_go) arvalid <= 1'b0;
      rready <= !r_go;
    end while (!r_go);
  endtask
  task automatic check_reg(input int k);
    axi_rd(addr_tab[k]);
    chk_data(rd, {24'h0, exp_reg[k]});
    chk_resp(rsp, ISC_RESP_OKAY);
  endtask
  task automatic wr_chk(input int k, input logic [7:0] d);
    axi_wr(addr_tab[k], d, 4'hf);
    chk_resp(rsp, ISC_RESP_OKAY);
    exp_reg[k] = (d & ISC_REG_MASK[k]) | (exp_reg[k] & ~ISC_REG_MASK[k]);
    @(negedge clk);
  endtask
  task automatic fuse_all;
    for (int k = 0; k < 4; k++) exp_reg[k] = fuse_exp(k, fuse[k]);
  endtask
  initial begin
    #(100 * 30000);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    addr_tab = '{{ISC_IDX_ILIM, 2'b00}, {ISC_IDX_PHY, 2'b00}, {ISC_IDX_DBNC, 2'b00},
      {ISC_IDX_HEADROOM, 2'b00}};
    for (int k = 0; k < 4; k++) fuse[k] = 8'($random(seed));
    for (int k = 0; k < 4; k++) exp_reg[k] = ISC_REG_DEFAULT[k];
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_fields();
    @(posedge clk);
    rstn <= 1'b1;
    chg_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    fuse_all();
    chk_fields();
    for (int k = 0; k < 4; k++) check_reg(k);
    $display("test reset_fuse done");
    for (int c = 0; c <= 20; c++) begin
      wr_chk(0, {5'(c), 3'h5});
      chk_data({21'h0, cur_ma}, {21'h0, ilim_ma(5'(c))});
      chk_fields();
    end
    $display("test current_codes done");
    repeat (30) begin
      s = $random(seed) & 3;
      wr_chk(s, 8'($random(seed)));
      check_reg(s);
      chk_fields();
    end
    $display("test random_rw done");
    axi_rd(8'h00);
    chk_resp(rsp, ISC_RESP_DECERR);
    chk_data(rd, 32'h0);
    axi_rd(addr_tab[0] + 8'h01);
    chk_resp(rsp, ISC_RESP_DECERR);
    axi_wr({ISC_IDX_STATUS, 2'b00}, 8'hff, 4'hf);
    chk_resp(rsp, ISC_RESP_SLVERR);
    axi_wr(addr_tab[1], ~exp_reg[1], 4'h0);
    chk_resp(rsp, ISC_RESP_OKAY);
    check_reg(1);
    $display("test bus_errors done");
    @(posedge clk);
    chg_rst_n <= 1'b0;
    exp_reg[0] = ISC_REG_DEFAULT[0];
    @(negedge clk);
    chk_fields();
    @(posedge clk);
    chg_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    exp_reg[0] = fuse_exp(0, fuse[0]);
    chk_fields();
    wr_chk(0, 8'ha0);
    @(posedge clk);
    rstn <= 1'b0;
    for (int k = 1; k < 4; k++) exp_reg[k] = ISC_REG_DEFAULT[k];
    @(negedge clk);
    chk_fields();
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 1; k < 4; k++) exp_reg[k] = fuse_exp(k, fuse[k]);
    for (int k = 0; k < 4; k++) check_reg(k);
    $display("test resets done");
    wrap_up();
  end
endmodule // isc_config_regs_tb
`default_nettype wire
